// >>> src/ast_transceiver.sv
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`default_nettype none
module ast_transceiver
    import ast_pkg::*;
#(
    parameter int CLK_HZ      = CLK_HZ_DEF,
    parameter int RECOVER_CYC = RECOVER_CYC_DEF
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [31:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic [3:0]  rx_pins,
    output logic             pin3_out,
    output logic             pin3_oe,
    output logic             pin4_out,
    output logic             pin4_oe,
    output logic             rx_irq
);
    localparam int               RCV_W    = $clog2(RECOVER_CYC + 1);
    localparam logic [RCV_W-1:0] RCV_LAST = RCV_W'(RECOVER_CYC - 1);

    typedef struct packed {
        logic                         awready;
        logic                         wready;
        logic                         bvalid;
        logic [1:0]                   bresp;
        logic                         arready;
        logic                         rvalid;
        logic [1:0]                   rresp;
        logic [31:0]                  rdata;
        ast_cfg_t                     cfg;
        logic                         trans;
        logic [TX_SLOTS-1:0][7:0]     txb;
        logic [3:0]                   sync1;
        logic [3:0]                   sync2;
        logic [RCV_W-1:0]             rcv_cnt;
        logic                         recovered;
        ast_tx_t                      tx_st;
        logic [3:0]                   tx_ovs;
        logic [3:0]                   tx_bit;
        logic [3:0]                   tx_slot;
        logic [4:0]                   tx_left;
        logic [10:0]                  tx_frm;
        logic                         txd;
        ast_rx_t                      rx_st;
        logic [3:0]                   rx_ovs;
        logic [3:0]                   rx_bit;
        logic [9:0]                   rx_sh;
        logic                         rx_flag;
        logic                         rx_pend;
        logic                         tx_done;
        logic                         ninth;
        logic                         data_par;
        logic                         start_lvl;
        logic                         stop_lvl;
        logic [7:0]                   rx_buf;
        logic                         p3_o;
        logic                         p3_oe;
        logic                         p4_o;
        logic                         p4_oe;
        logic                         irq;
    } ast_st_t;

    ast_st_t    s, s_d;
    logic       tick;
    logic       line;
    logic       start_req;
    logic       stopb;
    logic [3:0] last_idx;
    ast_stat_t  stat;

    function automatic ast_st_t rst_st();
        ast_st_t r;
        r       = '0;
        r.tx_st = TX_IDLE;
        r.rx_st = RX_IDLE;
        r.txd   = 1'b1;
        r.sync1 = '1;
        r.sync2 = '1;
        return r;
    endfunction : rst_st

    // byte-lane merge shared by the control word and the slot words
    function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    // whole frame, start at bit 0 so it can shift out from the bottom
    function automatic logic [10:0] frame(logic [7:0] d, logic m10, logic odd);
        if (m10) begin
            return {1'b1, (^d) ^ odd, d, 1'b0};
        end
        return {2'b11, d, 1'b0};
    endfunction : frame

    ast_baud_gen #(
        .CLK_HZ(CLK_HZ)
    ) u_baud (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .run       (s.recovered && s.cfg.clk_en),
        .baud_code (s.cfg.baud),
        .tick      (tick)
    );

    // status view of the current state
    always_comb begin
        stat           = '0;
        stat.rx_buf    = s.rx_buf;
        stat.recovered = s.recovered;
        stat.tx_busy   = (s.tx_st == TX_SEND);
        stat.stop_lvl  = s.stop_lvl;
        stat.start_lvl = s.start_lvl;
        stat.data_par  = s.data_par;
        stat.ninth     = s.ninth;
        stat.tx_done   = s.tx_done;
        stat.rx_flag   = s.rx_flag;
    end

    always_comb begin
        s_d       = s;
        start_req = 1'b0;
        s_d.sync1 = rx_pins;
        s_d.sync2 = s.sync1;
        line      = s.sync2[s.cfg.rx_sel];
        last_idx  = s.cfg.mode10 ? LAST_10 : LAST_9;
        stopb     = 1'b1;

        // write channel: wait for address and data together, answer next cycle
        if (s.bvalid && bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s.awready) begin
            s_d.awready = 1'b0;
            s_d.wready  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = RESP_OKAY;
            if (awaddr[31:ADDR_W] != '0) begin
                s_d.bresp = RESP_SLVERR;
            end else if (awaddr[A_TXB_BIT]) begin
                s_d.txb[{awaddr[3:2], 2'b00} +: 4] = merge(s.txb[{awaddr[3:2], 2'b00} +: 4], wdata, wstrb);
            end else if (awaddr[ADDR_W-1:2] == A_CTRL[ADDR_W-1:2]) begin
                s_d.cfg         = merge(s.cfg, wdata, wstrb);
                s_d.cfg.rsvd_hi = '0;
                s_d.cfg.rsvd_lo = '0;
            end else if (awaddr[ADDR_W-1:2] == A_CMD[ADDR_W-1:2]) begin
                if (wstrb[0]) begin
                    start_req = s.trans && !wdata[CMD_TRANS];
                    s_d.trans = wdata[CMD_TRANS];
                    if (wdata[CMD_ACK]) begin
                        s_d.rx_flag = 1'b0;
                        s_d.rx_pend = 1'b0;
                    end
                end
            end else if (awaddr[ADDR_W-1:2] != A_STAT[ADDR_W-1:2]) begin
                s_d.bresp = RESP_SLVERR;
            end
        end else if (awvalid && wvalid && !s.bvalid) begin
            s_d.awready = 1'b1;
            s_d.wready  = 1'b1;
        end

        // read channel
        if (s.rvalid && rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s.arready) begin
            s_d.arready = 1'b0;
            s_d.rvalid  = 1'b1;
            s_d.rresp   = RESP_OKAY;
            s_d.rdata   = '0;
            if (araddr[31:ADDR_W] != '0) begin
                s_d.rresp = RESP_SLVERR;
            end else if (araddr[A_TXB_BIT]) begin
                s_d.rdata = s.txb[{araddr[3:2], 2'b00} +: 4];
            end else if (araddr[ADDR_W-1:2] == A_CTRL[ADDR_W-1:2]) begin
                s_d.rdata = s.cfg;
            end else if (araddr[ADDR_W-1:2] == A_CMD[ADDR_W-1:2]) begin
                s_d.rdata = {31'h0000_0000, s.trans};
            end else if (araddr[ADDR_W-1:2] == A_STAT[ADDR_W-1:2]) begin
                s_d.rdata = stat;
            end else begin
                s_d.rresp = RESP_SLVERR;
            end
        end else if (arvalid && !s.rvalid) begin
            s_d.arready = 1'b1;
        end

        // recovery count after module enable
        if (!s.recovered) begin
            if (s.rcv_cnt == RCV_LAST) begin
                s_d.recovered = 1'b1;
            end else begin
                s_d.rcv_cnt = s.rcv_cnt + 1'b1;
            end
        end

        // transmitter
        unique case (s.tx_st)
            TX_IDLE: begin
                if (start_req && s.recovered) begin
                    s_d.tx_left = (s.cfg.tx_count > TX_MAX) ? TX_MAX : s.cfg.tx_count;
                    s_d.tx_slot = '0;
                    s_d.tx_bit  = '0;
                    s_d.tx_ovs  = '0;
                    s_d.tx_done = (s.cfg.tx_count == '0);
                    s_d.tx_frm  = frame(s.txb[0], s.cfg.mode10, s.cfg.parity_odd);
                    if (s.cfg.tx_count != '0) begin
                        s_d.tx_st = TX_SEND;
                    end
                end
            end
            TX_SEND: begin
                if (tick) begin
                    s_d.tx_ovs = s.tx_ovs + 1'b1;
                    if (s.tx_ovs == OVS_LAST) begin
                        if (s.tx_bit != last_idx) begin
                            s_d.tx_bit = s.tx_bit + 1'b1;
                            s_d.tx_frm = {1'b1, s.tx_frm[10:1]};
                        end else if (s.tx_left == 5'h01) begin
                            s_d.tx_left = '0;
                            s_d.tx_st   = TX_IDLE;
                            s_d.tx_done = 1'b1;
                        end else begin
                            s_d.tx_left = s.tx_left - 1'b1;
                            s_d.tx_slot = s.tx_slot + 1'b1;
                            s_d.tx_bit  = '0;
                            s_d.tx_frm  = frame(s.txb[s_d.tx_slot], s.cfg.mode10, s.cfg.parity_odd);
                        end
                    end
                end
            end
        endcase

        // receiver
        unique case (s.rx_st)
            RX_IDLE: begin
                // a set rx_flag holds the receiver off until acknowledged, even when rx_pend stayed low
                if (!line && s.cfg.rec_en && !s.cfg.rec_inhibit && !s.rx_flag
                    && s.recovered && s.cfg.clk_en) begin
                    s_d.rx_st  = RX_START;
                    s_d.rx_ovs = '0;
                end
            end
            RX_START: begin
                if (tick) begin
                    s_d.rx_ovs = s.rx_ovs + 1'b1;
                    if (s.rx_ovs == OVS_MID) begin
                        s_d.rx_ovs = '0;
                        s_d.rx_bit = '0;
                        s_d.rx_st  = line ? RX_IDLE : RX_BITS;
                    end
                end
            end
            RX_BITS: begin
                if (tick) begin
                    s_d.rx_ovs = s.rx_ovs + 1'b1;
                    if (s.rx_ovs == OVS_LAST) begin
                        s_d.rx_sh[s.rx_bit] = line;
                        s_d.rx_bit = s.rx_bit + 1'b1;
                        if (s.rx_bit == last_idx - 1'b1) begin
                            s_d.rx_st = RX_IDLE;
                            stopb     = s.cfg.mode10 ? s_d.rx_sh[9] : s_d.rx_sh[8];
                            if (!(s.cfg.stop_check && !stopb) && !s.cfg.rec_inhibit) begin
                                s_d.rx_buf    = s_d.rx_sh[7:0];
                                s_d.rx_flag   = 1'b1;
                                s_d.ninth     = s_d.rx_sh[8];
                                s_d.data_par  = ^s_d.rx_sh[7:0];
                                s_d.start_lvl = 1'b0;            // only a low start survives the filter
                                s_d.stop_lvl  = stopb;
                                s_d.rx_pend   = !s.cfg.mp_filter || s_d.rx_sh[8];
                            end
                        end
                    end
                end
            end
            default: begin
                s_d.rx_st = RX_IDLE;
            end
        endcase

        // module enable low holds the serial side in reset
        if (!s.cfg.module_en) begin
            s_d.recovered = 1'b0;
            s_d.rcv_cnt   = '0;
            s_d.tx_st     = TX_IDLE;
            s_d.rx_st     = RX_IDLE;
            s_d.rx_flag   = 1'b0;
            s_d.rx_pend   = 1'b0;
            s_d.tx_done   = 1'b0;
        end

        // pin drive registered so every output comes from a flop
        s_d.txd   = (s_d.tx_st == TX_SEND) ? s_d.tx_frm[0] : 1'b1;
        s_d.p3_oe = (s_d.cfg.pin3_function_select == FUNC_SERIAL);
        s_d.p4_oe = (s_d.cfg.pin4_function_select == FUNC_SERIAL);
        s_d.p3_o  = s_d.p3_oe && s_d.txd;
        s_d.p4_o  = s_d.p4_oe && s_d.txd;
        s_d.irq   = s_d.rx_pend && s_d.cfg.irq_en;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= rst_st();
        end else begin
            s <= s_d;
        end
    end

    assign awready  = s.awready;
    assign wready   = s.wready;
    assign bvalid   = s.bvalid;
    assign bresp    = s.bresp;
    assign arready  = s.arready;
    assign rvalid   = s.rvalid;
    assign rresp    = s.rresp;
    assign rdata    = s.rdata;
    assign pin3_out = s.p3_o;
    assign pin3_oe  = s.p3_oe;
    assign pin4_out = s.p4_o;
    assign pin4_oe  = s.p4_oe;
    assign rx_irq   = s.irq;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_start_low: assert property ($rose(s.tx_st == TX_SEND) |-> !s.txd) else $error("start bit not low");
    a_idle_high: assert property (s.tx_st == TX_IDLE |-> s.txd) else $error("idle line not high");
    a_done_end: assert property ($rose(s.tx_done) |-> s.tx_left == '0 && $past(s.txd)) else $error("bad done");
    a_rx_blocked: assert property (s.rx_flag && s.rx_st == RX_IDLE |=> s.rx_st == RX_IDLE) else $error("rx ran");
    a_inhibit_hold: assert property (s.cfg.rec_inhibit |=> !$rose(s.rx_flag)) else $error("byte taken");
    a_irq_gated: assert property (!s.cfg.irq_en |-> !rx_irq) else $error("irq not gated");
    a_mp_filter: assert property ($rose(s.rx_pend) |-> s.rx_flag && (!s.cfg.mp_filter || s.ninth))
        else $error("filter broken");
    a_stop_valid: assert property ($rose(s.rx_flag) && s.cfg.stop_check |-> s.stop_lvl) else $error("no stop");
    a_data_parity: assert property ($rose(s.rx_flag) |-> s.data_par == ^s.rx_buf) else $error("parity");
    a_recover_wait: assert property ($rose(s.recovered) |-> $past(s.rcv_cnt) == RCV_LAST)
        else $error("early release");

    c_tx_done: cover property ($rose(s.tx_done));
    c_rx_byte: cover property ($rose(s.rx_flag));
    c_glitch: cover property (s.rx_st == RX_START ##1 s.rx_st == RX_IDLE);
    c_filtered: cover property ($rose(s.rx_flag) && !s_d.rx_pend && s.cfg.mp_filter);
endmodule : ast_transceiver
`default_nettype wire

// >>> src/ast_pkg.sv
`default_nettype none
package ast_pkg;
    // clock and timing base
    localparam int CLK_PERIOD_NS   = 5;
    localparam int CLK_HZ_DEF      = 200_000_000;
    localparam int RECOVER_NS      = 50_000;
    // least time, so round up to whole cycles
    localparam int RECOVER_CYC_DEF = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // oversampling of each bit period
    localparam int         OVS      = 16;
    localparam logic [3:0] OVS_MID  = 4'h7;
    localparam logic [3:0] OVS_LAST = 4'hf;

    // frame layout: index of the last bit, start bit at index 0
    localparam logic [3:0] LAST_9   = 4'h9;
    localparam logic [3:0] LAST_10  = 4'ha;
    localparam logic [4:0] TX_MAX   = 5'h10;
    localparam int         TX_SLOTS = 16;

    // register map, byte addresses
    localparam int         ADDR_W = 5;
    localparam logic [4:0] A_CTRL = 5'h00;
    localparam logic [4:0] A_CMD  = 5'h04;
    localparam logic [4:0] A_STAT = 5'h08;
    localparam int         A_TXB_BIT = 4;
    localparam int         CMD_TRANS = 0;
    localparam int         CMD_ACK   = 1;
    localparam logic [1:0] FUNC_SERIAL = 2'h2;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [3:0] rsvd_hi;
        logic [1:0] pin4_function_select;
        logic [1:0] pin3_function_select;
        logic [2:0] rsvd_lo;
        logic [4:0] tx_count;
        logic       module_en;
        logic       rec_inhibit;
        logic       rec_en;
        logic       irq_en;
        logic       mp_filter;
        logic       stop_check;
        logic [1:0] rx_sel;
        logic [3:0] baud;
        logic       parity_odd;
        logic       mode10;
        logic       clock_source_divider_select;
        logic       clk_en;
    } ast_cfg_t;

    typedef struct packed {
        logic [15:0] zero;
        logic [7:0]  rx_buf;
        logic        recovered;
        logic        tx_busy;
        logic        stop_lvl;
        logic        start_lvl;
        logic        data_par;
        logic        ninth;
        logic        tx_done;
        logic        rx_flag;
    } ast_stat_t;

    typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} ast_tx_t;
    typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_START = 3'b010, RX_BITS = 3'b100} ast_rx_t;

    // baud code to bit rate; codes above the table run at the top rate
    function automatic int baud_rate(logic [3:0] code);
        case (code)
            4'h0:    return 300;
            4'h1:    return 600;
            4'h2:    return 1200;
            4'h3:    return 2400;
            4'h4:    return 4800;
            4'h5:    return 9600;
            4'h6:    return 19200;
            4'h7:    return 38400;
            4'h8:    return 57600;
            4'h9:    return 76800;
            default: return 115200;
        endcase
    endfunction : baud_rate
endpackage : ast_pkg
`default_nettype wire

// >>> src/ast_baud_gen.sv
`default_nettype none
module ast_baud_gen
    import ast_pkg::*;
#(
    parameter int CLK_HZ = CLK_HZ_DEF
) (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       run,
    input  wire logic [3:0] baud_code,
    output logic            tick
);
    localparam int CNT_W = 24;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             tick;
    } ast_bg_st_t;

    ast_bg_st_t s, s_d;

    // reload value for one oversample period, rounded to nearest
    function automatic logic [CNT_W-1:0] reload(logic [3:0] code);
        int d;
        d = (CLK_HZ + (OVS * baud_rate(code)) / 2) / (OVS * baud_rate(code));
        if (d < 1) begin
            d = 1;
        end
        return CNT_W'(d - 1);
    endfunction : reload

    // rate depends only on the code, so both clock-source settings give equal baud
    always_comb begin
        s_d      = s;
        s_d.tick = 1'b0;
        if (!run) begin
            s_d.cnt = '0;
        end else if (s.cnt == '0) begin
            s_d.cnt  = reload(baud_code);
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s.cnt - 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= s_d;
        end
    end

    assign tick = s.tick;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_tick_halted: assert property (!run ##1 !run |=> !tick) else $error("tick while stopped");
endmodule : ast_baud_gen
`default_nettype wire

// >>> dv/ast_serial_dev.sv
`default_nettype none
module ast_serial_dev #(
    parameter int BIT_CYC = 160
) (
    input  wire logic aclk,
    input  wire logic txd,
    output logic      rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [10:0] got_q[$];
    initial rxd = 1'b1;
    // decoder: mid-bit samples of start, data lsb first, two trailing bits
    initial begin : dec
        logic [10:0] f;
        forever begin
            @(negedge txd);
            repeat (BIT_CYC / 2) @(posedge aclk);
            for (int i = 0; i < 11; i++) begin
                f[i] = txd;
                if (i < 10) repeat (BIT_CYC) @(posedge aclk);
            end
            got_q.push_back(f);
        end
    end
    // parity frame; the caller picks the stop level so a broken frame can be sent
    task automatic send(input logic [7:0] d, input logic p, input logic s);
        logic [10:0] f;
        f = {s, p, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            rxd <= f[i];
            repeat (BIT_CYC) @(posedge aclk);
        end
        rxd <= 1'b1; // line idles high between frames
        repeat (BIT_CYC) @(posedge aclk);
    endtask : send
endmodule : ast_serial_dev
`default_nettype wire

// >>> dv/async_serial_transceiver_tb.sv
`default_nettype none
module async_serial_transceiver_tb
    import ast_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
    $display("Error %0t: got %h exp %h", $time, a, b); end end
    localparam logic [31:0] TXW = 32'h3cff00a5;
    logic        aclk = 1'b0, aresetn = 1'b0, rxd;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, d;
    logic [3:0]  wstrb = '0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, p3o, p3e, p4o, p4e, rx_irq;
    logic [1:0]  bresp, rresp, r;
    int          failures = 0, check_count = 0, cyc = 0;

    ast_transceiver #(.CLK_HZ(18432000), .RECOVER_CYC(20)) ast_transceiver_i (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .rx_pins({rxd, 3'h7}),
        .pin3_out(p3o), .pin3_oe(p3e), .pin4_out(p4o), .pin4_oe(p4e), .rx_irq(rx_irq));
    // released pin reads as pulled up
    ast_serial_dev #(.BIT_CYC(160)) ast_serial_dev_i (.aclk(aclk), .txd(p3e ? p3o : 1'b1), .rxd(rxd));

    initial forever #2.5 aclk = ~aclk;
    // hang guard, well above the sum of all frames
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            failures++;
            end_of_test();
        end
    end

    task automatic end_of_test;
        $display("failures %0d checks %0d", failures, check_count);
        if (failures == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    // baud code 10, receive on rx_pins bit 3, stop check on, transmit routed to pin 3
    function automatic logic [31:0] ctl(logic m10, logic po, logic mpf, logic inh, logic [4:0] n);
        return {8'h02, 3'h0, n, 1'b1, inh, 2'h3, mpf, 3'h7, 4'ha, po, m10, 2'h3};
    endfunction : ctl
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        awaddr  <= {27'h0, a};
        wdata   <= v;
        wstrb   <= 4'hf;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [4:0] a);
        araddr  <= {27'h0, a};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rd
    // slots go out in order; frames judged bit by bit at the pin
    task automatic t_tx(input logic m10, input logic po, input int n);
        logic [7:0] b;
        logic [10:0] f;
        wr(A_CTRL, ctl(m10, po, 1'b0, 1'b0, 5'(n)));
        wr(5'h10, TXW);
        wr(A_CMD, 32'h1);
        wr(A_CMD, 32'h0);
        do rd(A_STAT); while (d[1] !== 1'b1);
        // the model takes its last sample half a bit after the stop bit ends without parity, mid stop bit with parity
        repeat (160) @(posedge aclk);
        `CHK(ast_serial_dev_i.got_q.size(), n)
        for (int i = 0; i < n; i++) begin
            b = 8'(TXW >> (8 * i));
            f = ast_serial_dev_i.got_q.pop_front();
            `CHK(f, m10 ? {1'b1, ^b ^ po, b, 1'b0} : {1'b1, 1'b1, b, 1'b0})
        end
    endtask : t_tx
    // one received frame, then status, interrupt and acknowledge
    task automatic t_rx(input logic [7:0] b, input logic p, s, mpf, inh, fl, irq);
        wr(A_CTRL, ctl(1'b1, 1'b0, mpf, inh, 5'h3));
        ast_serial_dev_i.send(b, p, s);
        repeat (40) @(posedge aclk);
        `CHK(rx_irq, irq)
        rd(A_STAT);
        `CHK(d[0], fl)
        if (fl) `CHK(d[15:2], {b, 2'h2, s, 1'b0, ^b, p})
        wr(A_CMD, 32'h2);
        rd(A_STAT);
        `CHK({d[0], rx_irq}, 2'h0)
    endtask : t_rx

    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        wr(A_CTRL, ctl(1'b1, 1'b1, 1'b0, 1'b0, 5'h3));
        rd(A_STAT);
        `CHK(d[7], 1'b0)
        do rd(A_STAT); while (d[7] !== 1'b1);
        `CHK({p4e, p3e}, 2'h1)
        t_tx(1'b1, 1'b1, 3);
        t_tx(1'b1, 1'b0, 3);
        t_tx(1'b0, 1'b0, 1);
        t_rx(8'h96, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
        t_rx(8'h5b, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
        t_rx(8'h5b, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
        t_rx(8'h77, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        rd(5'h0c);
        `CHK(r, RESP_SLVERR)
        t_rx(8'h3c, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        end_of_test();
    end
endmodule : async_serial_transceiver_tb
`default_nettype wire
